// [pkg/swcfg_params.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef SWCFG_PARAMS_SVH
`define SWCFG_PARAMS_SVH

`define SWCFG_ADDR_W 6
`define SWCFG_DATA_W 24
`define SWCFG_NUM_CH 24
`define SWCFG_NUM_WC 12
`define SWCFG_NUM_CS 10

`define SWCFG_OFS_MAIN_CONTROL 6'h1a
`define SWCFG_OFS_CHANNEL_ENABLE 6'h1b
`define SWCFG_OFS_SOURCE_SINK_SELECT 6'h1c
`define SWCFG_OFS_WETTING_CFG_LOW 6'h1d

`define SWCFG_RST_MAIN_CONTROL 24'h000000
`define SWCFG_RST_CHANNEL_ENABLE 24'h000000
`define SWCFG_RST_SOURCE_SINK_SELECT 24'h000000
`define SWCFG_RST_WETTING_CFG_LOW 24'h000000

`define SWCFG_BIT_SOFT_RESET 0
`define SWCFG_BIT_POLL_TIME_LO 1
`define SWCFG_BIT_POLL_TIME_HI 4
`define SWCFG_BIT_POLL_EN 10
`define SWCFG_BIT_TRIGGER 11
`define SWCFG_CS_MASK 24'h0003ff

`define SWCFG_WC_W 3
`define SWCFG_MA_W 4

`define SWCFG_CLK_MHZ 100
`define SWCFG_US_PER_MS 1000

`define SWCFG_POLL_MS_0 13'd2
`define SWCFG_POLL_MS_1 13'd4
`define SWCFG_POLL_MS_2 13'd8
`define SWCFG_POLL_MS_3 13'd16
`define SWCFG_POLL_MS_4 13'd32
`define SWCFG_POLL_MS_5 13'd48
`define SWCFG_POLL_MS_6 13'd64
`define SWCFG_POLL_MS_7 13'd128
`define SWCFG_POLL_MS_8 13'd256
`define SWCFG_POLL_MS_9 13'd512
`define SWCFG_POLL_MS_A 13'd1024
`define SWCFG_POLL_MS_B 13'd2048
`define SWCFG_POLL_MS_C 13'd4096
`define SWCFG_POLL_MS_DFLT 13'd8

`define SWCFG_MA_OFF 4'h0
`define SWCFG_MA_1 4'h1
`define SWCFG_MA_2 4'h2
`define SWCFG_MA_5 4'h5
`define SWCFG_MA_10 4'ha
`define SWCFG_MA_15 4'hf

`endif

// [pkg/swcfg_pkg.sv]
// Types shared by the switch input configuration block
package swcfg_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [23:0] wdata;
    } swcfg_req_s;

    typedef struct packed {
        logic trigger;
        logic poll_en;
        logic [3:0] poll_time;
    } swcfg_ctrl_s;

    typedef struct packed {
        logic valid;
        logic [4:0] chan;
    } swcfg_sample_s;

    typedef enum logic [2:0] {
        SWCFG_IDLE = 3'b001,
        SWCFG_WAIT = 3'b010,
        SWCFG_SCAN = 3'b100
    } swcfg_state_e;

endpackage : swcfg_pkg

// [rtl/swcfg_wet_decode.sv]
// Wetting current code to milliamp value
`timescale 1ns/100ps
`include "swcfg_params.svh"
module swcfg_wet_decode (
    input wire logic [2:0] code,
    output logic [3:0] ma
);
    always_comb begin
        case (code)
            3'h0: ma = `SWCFG_MA_OFF;
            3'h1: ma = `SWCFG_MA_1;
            3'h2: ma = `SWCFG_MA_2;
            3'h3: ma = `SWCFG_MA_5;
            3'h4: ma = `SWCFG_MA_10;
            default: ma = `SWCFG_MA_15;
        endcase
    end
endmodule : swcfg_wet_decode

// [rtl/swcfg_poll_timer.sv]
// Poll period timer: one pulse per selected period
`timescale 1ns/100ps
`include "swcfg_params.svh"
module swcfg_poll_timer #(
    parameter int CYC_PER_MS = `SWCFG_CLK_MHZ * `SWCFG_US_PER_MS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic [3:0] poll_time,
    output logic tick
);
    logic [16:0] cyc;
    logic [12:0] ms;
    logic [12:0] period_ms;
    logic ms_edge;

    always_comb begin
        case (poll_time)
            4'h0: period_ms = `SWCFG_POLL_MS_0;
            4'h1: period_ms = `SWCFG_POLL_MS_1;
            4'h2: period_ms = `SWCFG_POLL_MS_2;
            4'h3: period_ms = `SWCFG_POLL_MS_3;
            4'h4: period_ms = `SWCFG_POLL_MS_4;
            4'h5: period_ms = `SWCFG_POLL_MS_5;
            4'h6: period_ms = `SWCFG_POLL_MS_6;
            4'h7: period_ms = `SWCFG_POLL_MS_7;
            4'h8: period_ms = `SWCFG_POLL_MS_8;
            4'h9: period_ms = `SWCFG_POLL_MS_9;
            4'ha: period_ms = `SWCFG_POLL_MS_A;
            4'hb: period_ms = `SWCFG_POLL_MS_B;
            4'hc: period_ms = `SWCFG_POLL_MS_C;
            default: period_ms = `SWCFG_POLL_MS_DFLT;
        endcase
    end

    assign ms_edge = (cyc == 17'(CYC_PER_MS - 1));

    always_ff @(posedge clk) begin
        if (srst || !run || ms_edge) begin
            cyc <= 17'h00000;
        end else begin
            cyc <= cyc + 17'h00001;
        end
    end

    // Period shortened mid-count: wrap at once rather than run to overflow
    always_ff @(posedge clk) begin
        if (srst || !run) begin
            ms <= 13'h0000;
            tick <= 1'b0;
        end else if (ms_edge) begin
            if (ms >= period_ms - 13'h0001) begin
                ms <= 13'h0000;
                tick <= 1'b1;
            end else begin
                ms <= ms + 13'h0001;
                tick <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end
endmodule : swcfg_poll_timer

// [rtl/swcfg_top.sv]
// Switch input configuration registers with poll sequencer
`timescale 1ns/100ps
`include "swcfg_params.svh"

module swcfg_top #(
    parameter int CYC_PER_MS = `SWCFG_CLK_MHZ * `SWCFG_US_PER_MS
) (
    input wire logic clk,
    input wire logic srst,
    input wire swcfg_pkg::swcfg_req_s req,
    output logic [23:0] rdata,
    output logic rvalid,
    output logic [23:0] channel_enable_q,
    output logic [9:0] current_sink,
    output logic [9:0] source_mode,
    output logic [47:0] wet_ma,
    output logic running,
    output logic poll_mode,
    output swcfg_pkg::swcfg_sample_s sample,
    output logic scan_done
);
    import swcfg_pkg::*;

    swcfg_ctrl_s ctrl;
    logic [23:0] channel_enable;
    logic [23:0] source_sink_select;
    logic [23:0] wetting_current_cfg_low;
    logic soft_reset;
    logic blk_rst;
    logic [35:0] wet_code;
    logic [47:0] next_wet_ma;
    logic period_tick;
    swcfg_state_e state;
    swcfg_state_e next_state;
    logic [4:0] chan;
    logic [4:0] next_chan;
    logic chan_found;
    logic [23:0] above_mask;
    logic [23:0] pending;

    // Software reset acts on the same write, so the bit is never stored
    assign soft_reset = req.wr && (req.addr == `SWCFG_OFS_MAIN_CONTROL)
        && req.wdata[`SWCFG_BIT_SOFT_RESET];
    assign blk_rst = srst || soft_reset;

    // Main control register
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            ctrl <= swcfg_ctrl_s'(6'h00);
        end else if (req.wr && req.addr == `SWCFG_OFS_MAIN_CONTROL) begin
            ctrl.trigger <= req.wdata[`SWCFG_BIT_TRIGGER];
            ctrl.poll_en <= req.wdata[`SWCFG_BIT_POLL_EN];
            ctrl.poll_time <= req.wdata[`SWCFG_BIT_POLL_TIME_HI:
                `SWCFG_BIT_POLL_TIME_LO];
        end
    end

    // Channel enable register
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            channel_enable <= `SWCFG_RST_CHANNEL_ENABLE;
        end else if (req.wr && req.addr == `SWCFG_OFS_CHANNEL_ENABLE) begin
            channel_enable <= req.wdata;
        end
    end

    // Source/sink selection register, upper bits tied off
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            source_sink_select <= `SWCFG_RST_SOURCE_SINK_SELECT;
        end else if (req.wr && req.addr == `SWCFG_OFS_SOURCE_SINK_SELECT)
        begin
            source_sink_select <= req.wdata & `SWCFG_CS_MASK;
        end
    end

    // Low wetting current register
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            wetting_current_cfg_low <= `SWCFG_RST_WETTING_CFG_LOW;
        end else if (req.wr && req.addr == `SWCFG_OFS_WETTING_CFG_LOW) begin
            wetting_current_cfg_low <= req.wdata;
        end
    end

    // Read port: answer one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 24'h000000;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (!req.rd) begin
                rdata <= 24'h000000;
            end else if (req.addr == `SWCFG_OFS_MAIN_CONTROL) begin
                rdata <= {12'h000, ctrl.trigger, ctrl.poll_en, 5'h00,
                    ctrl.poll_time, 1'b0};
            end else if (req.addr == `SWCFG_OFS_CHANNEL_ENABLE) begin
                rdata <= channel_enable;
            end else if (req.addr == `SWCFG_OFS_SOURCE_SINK_SELECT) begin
                rdata <= source_sink_select & `SWCFG_CS_MASK;
            end else if (req.addr == `SWCFG_OFS_WETTING_CFG_LOW) begin
                rdata <= wetting_current_cfg_low;
            end else begin
                rdata <= 24'h000000;
            end
        end
    end

    // Per-input wetting codes; paired fields feed both inputs
    assign wet_code[2:0] = wetting_current_cfg_low[2:0];
    assign wet_code[5:3] = wetting_current_cfg_low[2:0];
    assign wet_code[8:6] = wetting_current_cfg_low[5:3];
    assign wet_code[11:9] = wetting_current_cfg_low[5:3];
    assign wet_code[14:12] = wetting_current_cfg_low[8:6];
    assign wet_code[17:15] = wetting_current_cfg_low[11:9];
    assign wet_code[20:18] = wetting_current_cfg_low[14:12];
    assign wet_code[23:21] = wetting_current_cfg_low[14:12];
    assign wet_code[26:24] = wetting_current_cfg_low[17:15];
    assign wet_code[29:27] = wetting_current_cfg_low[17:15];
    assign wet_code[32:30] = wetting_current_cfg_low[20:18];
    assign wet_code[35:33] = wetting_current_cfg_low[23:21];

    genvar gi;
    generate
        for (gi = 0; gi < `SWCFG_NUM_WC; gi++) begin : g_wet
            swcfg_wet_decode u_dec (
                .code(wet_code[gi*3 +: 3]),
                .ma(next_wet_ma[gi*4 +: 4])
            );
        end
    endgenerate

    // Configuration outputs, registered
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            wet_ma <= 48'h000000000000;
            channel_enable_q <= 24'h000000;
            current_sink <= 10'h000;
            source_mode <= 10'h3ff;
            running <= 1'b0;
            poll_mode <= 1'b0;
        end else begin
            wet_ma <= next_wet_ma;
            channel_enable_q <= channel_enable;
            current_sink <= source_sink_select[9:0];
            source_mode <= ~source_sink_select[9:0];
            running <= ctrl.trigger;
            poll_mode <= ctrl.poll_en;
        end
    end

    swcfg_poll_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .clk(clk),
        .srst(blk_rst),
        .run(ctrl.trigger && ctrl.poll_en && state == SWCFG_WAIT),
        .poll_time(ctrl.poll_time),
        .tick(period_tick)
    );

    // Channels still due in this pass: enabled and not yet visited
    generate
        for (gi = 0; gi < `SWCFG_NUM_CH; gi++) begin : g_mask
            assign above_mask[gi] = (5'(gi) >= chan);
            assign pending[gi] = above_mask[gi] && channel_enable[gi];
        end
    endgenerate

    // Lowest pending channel
    always_comb begin
        next_chan = 5'h00;
        chan_found = 1'b0;
        for (int i = `SWCFG_NUM_CH - 1; i >= 0; i--) begin
            if (pending[i]) begin
                next_chan = 5'(i);
                chan_found = 1'b1;
            end
        end
    end

    // Sequencer state
    always_comb begin
        next_state = state;
        case (state)
            SWCFG_IDLE: begin
                if (ctrl.trigger) begin
                    next_state = ctrl.poll_en ? SWCFG_WAIT : SWCFG_SCAN;
                end
            end
            SWCFG_WAIT: begin
                if (!ctrl.trigger) begin
                    next_state = SWCFG_IDLE;
                end else if (!ctrl.poll_en) begin
                    next_state = SWCFG_SCAN;
                end else if (period_tick) begin
                    next_state = SWCFG_SCAN;
                end
            end
            SWCFG_SCAN: begin
                if (!ctrl.trigger) begin
                    next_state = SWCFG_IDLE;
                end else if (!chan_found && ctrl.poll_en) begin
                    next_state = SWCFG_WAIT;
                end
            end
            default: next_state = SWCFG_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (blk_rst) begin
            state <= SWCFG_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Walk pointer: jumps past disabled channels, wraps after a pass
    always_ff @(posedge clk) begin
        if (blk_rst || state != SWCFG_SCAN || !chan_found) begin
            chan <= 5'h00;
        end else begin
            chan <= next_chan + 5'h01;
        end
    end

    // Sample strobe and end-of-pass marker
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            sample <= swcfg_sample_s'(6'h00);
            scan_done <= 1'b0;
        end else begin
            sample.valid <= (state == SWCFG_SCAN) && ctrl.trigger
                && chan_found;
            sample.chan <= next_chan;
            scan_done <= (state == SWCFG_SCAN) && ctrl.trigger
                && !chan_found;
        end
    end

endmodule : swcfg_top

// [verif/swcfg_top_monitor.sv]
// Port checker for the switch input configuration block
`timescale 1ns/100ps
module swcfg_top_monitor #(
    parameter int CYC_PER_MS = 10
) (
    input wire logic clk,
    input wire logic srst,
    input wire swcfg_pkg::swcfg_req_s req,
    input wire logic [23:0] rdata,
    input wire logic rvalid,
    input wire logic [23:0] channel_enable_q,
    input wire logic [9:0] current_sink,
    input wire logic [9:0] source_mode,
    input wire logic [47:0] wet_ma,
    input wire logic running,
    input wire logic poll_mode,
    input wire swcfg_pkg::swcfg_sample_s sample,
    input wire logic scan_done
);
    import swcfg_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire logic w_ctl = req.wr && req.addr == 6'h1a;
    wire logic w_en = req.wr && req.addr == 6'h1b;
    wire logic w_cs = req.wr && req.addr == 6'h1c;
    wire logic w_wc = req.wr && req.addr == 6'h1d;
    function automatic logic [3:0] ma(input logic [2:0] c);
        return c > 3'h4 ? 4'hf : (c == 3'h4 ? 4'ha :
            (c == 3'h3 ? 4'h5 : {1'b0, c}));
    endfunction : ma
    AST_EN_STORE: assert property (
        w_en |-> ##2 channel_enable_q == $past(req.wdata, 2))
        else $error("enable output differs from written word");
    AST_SKIP_OFF: assert property (
        sample.valid |-> channel_enable_q[sample.chan])
        else $error("disabled channel visited");
    AST_ASCEND: assert property (
        sample.valid && $past(sample.valid)
        |-> sample.chan > $past(sample.chan))
        else $error("channels visited out of order");
    AST_SINK_STORE: assert property (
        w_cs |-> ##2 current_sink == $past(req.wdata[9:0], 2))
        else $error("sink select differs from written bits");
    AST_SRC_INV: assert property (
        source_mode == ~current_sink)
        else $error("source and sink disagree");
    AST_WET_FIELD: assert property (
        w_wc |-> ##2 wet_ma[47:44] == ma($past(req.wdata[23:21], 2))
        && wet_ma[19:16] == ma($past(req.wdata[8:6], 2)))
        else $error("wetting field decode wrong");
    AST_WET_PAIR: assert property (
        wet_ma[3:0] == wet_ma[7:4] && wet_ma[11:8] == wet_ma[15:12]
        && wet_ma[27:24] == wet_ma[31:28]
        && wet_ma[35:32] == wet_ma[39:36])
        else $error("paired inputs differ");
    AST_SOFT_RST: assert property (
        w_ctl && req.wdata[0] |-> ##2 channel_enable_q == 24'h0
        && wet_ma == 48'h0 && current_sink == 10'h0 && !running)
        else $error("software reset left state behind");
    AST_RUN_BITS: assert property (
        w_ctl && !req.wdata[0] |-> ##2 running == $past(req.wdata[11], 2)
        && poll_mode == $past(req.wdata[10], 2))
        else $error("run or poll output wrong");
    AST_ANSWER: assert property (req.rd |=> rvalid)
        else $error("read not answered");
endmodule : swcfg_top_monitor

bind swcfg_top swcfg_top_monitor #(.CYC_PER_MS(CYC_PER_MS)) u_mon (
    .clk(clk), .srst(srst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .channel_enable_q(channel_enable_q), .current_sink(current_sink),
    .source_mode(source_mode), .wet_ma(wet_ma), .running(running),
    .poll_mode(poll_mode), .sample(sample), .scan_done(scan_done));

// [verif/swcfg_mcu_model.sv]
// Register bus master standing in for the microcontroller
`timescale 1ns/100ps
module swcfg_mcu_model (
    input wire logic clk,
    input wire logic [23:0] rdata,
    output swcfg_pkg::swcfg_req_s req
);
    import swcfg_pkg::*;
    initial req = '0;
    task automatic access(input logic w, input logic [5:0] a,
                          input logic [23:0] d, output logic [23:0] q);
        @(negedge clk);
        req.wr = w;
        req.rd = !w;
        req.addr = a;
        req.wdata = d;
        @(negedge clk);
        q = rdata;
        req.wr = 1'b0;
        req.rd = 1'b0;
        // Stale data is not held after the strobe
        req.wdata = ~d;
    endtask : access
endmodule : swcfg_mcu_model

// [verif/switch_input_config_regs_tb_top.sv]
// Self-checking bench for the switch input configuration block
`timescale 1ns/100ps
module switch_input_config_regs_tb_top;
    import swcfg_pkg::*;
    localparam int CPM = 10;
    logic clk, srst, rvalid, running, poll_mode, scan_done;
    logic [23:0] rdata, channel_enable_q;
    logic [9:0] current_sink, source_mode;
    logic [47:0] wet_ma;
    logic [14:0] acc;
    swcfg_req_s req;
    swcfg_sample_s sample;
    int n_errors = 0;
    int comparisons = 0;
    int n, p0, p1, p2, pd, pf;
    logic [3:0] ma_tab [8] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'ha, 4'hf, 4'hf, 4'hf};
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    swcfg_top #(.CYC_PER_MS(CPM)) u_dut (.clk(clk), .srst(srst), .req(req),
        .rdata(rdata), .rvalid(rvalid), .channel_enable_q(channel_enable_q),
        .current_sink(current_sink), .source_mode(source_mode),
        .wet_ma(wet_ma), .running(running), .poll_mode(poll_mode),
        .sample(sample), .scan_done(scan_done));
    swcfg_mcu_model u_mcu (.clk(clk), .rdata(rdata), .req(req));
    task automatic chk(string what, logic [47:0] seen, logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [5:0] a, logic [23:0] d);
        logic [23:0] q;
        u_mcu.access(1'b1, a, d, q);
    endtask : wr
    task automatic rd(string what, logic [5:0] a, logic [23:0] exp);
        logic [23:0] q;
        u_mcu.access(1'b0, a, 24'h0, q);
        chk(what, 48'(q), 48'(exp));
        chk("read valid", 48'(rvalid), 48'h1);
    endtask : rd
    task automatic until_done(output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (scan_done !== 1'b1 && k < 300);
        // A pass that never ends counts as a mismatch
        chk("scan done", 48'(scan_done), 48'h1);
    endtask : until_done
    task automatic period(input logic [3:0] code, output int k);
        int m;
        wr(6'h1a, 24'h0);
        wr(6'h1a, 24'hc00 | {19'h0, code, 1'b0});
        until_done(m);
        until_done(k);
    endtask : period
    task automatic give_verdict();
        $display("counts: %0d comparisons, %0d mismatches", comparisons,
                 n_errors);
        if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        srst = 1'b1;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        rd("enable reset", 6'h1b, 24'h0);
        rd("select reset", 6'h1c, 24'h0);
        rd("wetting reset", 6'h1d, 24'h0);
        rd("control reset", 6'h1a, 24'h0);
        chk("source reset", 48'(source_mode), 48'h3ff);
        $display("done: reset values");
        wr(6'h1b, 24'hffffff);
        rd("enable rw", 6'h1b, 24'hffffff);
        wr(6'h1c, 24'hffffff);
        rd("select reserved", 6'h1c, 24'h0003ff);
        chk("sink pins", 48'({current_sink, source_mode}), 48'hffc00);
        for (int c = 0; c < 8; c++) begin
            wr(6'h1d, {8{c[2:0]}});
            rd("wetting rw", 6'h1d, {8{c[2:0]}});
            chk("wetting ma", wet_ma, {12{ma_tab[c]}});
        end
        wr(6'h1d, {3'd1, 3'd2, 3'd3, 3'd4, 3'd5, 3'd0, 3'd1, 3'd2});
        // Current outputs trail the register by one cycle
        @(negedge clk);
        chk("wetting map", wet_ma, 48'h1255aaf01122);
        wr(6'h3f, 24'habcdef);
        rd("unmapped", 6'h3f, 24'h0);
        $display("done: register access");
        wr(6'h1a, 24'hfffffe);
        rd("control rw", 6'h1a, 24'h000c1e);
        chk("run pins", 48'({running, poll_mode}), 48'h3);
        rd("no reset", 6'h1b, 24'hffffff);
        wr(6'h1a, 24'h0);
        wr(6'h1b, 24'h800005);
        wr(6'h1a, 24'h800);
        until_done(n);
        acc = '0;
        n = 0;
        do begin
            @(negedge clk);
            if (sample.valid === 1'b1) acc = {acc[9:0], sample.chan};
            n++;
        end while (scan_done !== 1'b1 && n < 100);
        chk("pass end", 48'(scan_done), 48'h1);
        chk("scan order", 48'(acc), 48'h57);
        $display("done: continuous scan");
        period(4'h0, p0);
        period(4'h1, p1);
        period(4'h2, p2);
        period(4'hd, pd);
        period(4'hf, pf);
        chk("poll 4ms", 48'(p1 - p0), 48'(2 * CPM));
        chk("poll 8ms", 48'(p2 - p0), 48'(6 * CPM));
        chk("poll code d", 48'(pd), 48'(p2));
        chk("poll code f", 48'(pf), 48'(p2));
        $display("done: poll periods");
        wr(6'h1a, 24'h801);
        rd("soft enable", 6'h1b, 24'h0);
        rd("soft wetting", 6'h1d, 24'h0);
        rd("soft control", 6'h1a, 24'h0);
        rd("soft select", 6'h1c, 24'h0);
        chk("soft source", 48'(source_mode), 48'h3ff);
        chk("soft run", 48'(running), 48'h0);
        $display("done: software reset");
        give_verdict();
    end
endmodule : switch_input_config_regs_tb_top
